// ===== dac_feeder_consts.vh
// Constants for the DAC sample feeder
`ifndef DAC_FEEDER_CONSTS_VH
`define DAC_FEEDER_CONSTS_VH

// Stream and sample widths
`define IN_WORD_WIDTH   32
`define IN_COMP_WIDTH   16
`define DAC_COMP_WIDTH  12
`define ROUND_SHIFT     4
`define ROUND_HALF      17'h00008
`define POS_LIMIT       12'h7FF

// Crossing buffer
`define FIFO_DEPTH      64
`define FIFO_AW         6

// APB register byte addresses
`define ADDR_WIDTH      12
`define REG_UNDERRUN    12'h000
`define REG_SPACING     12'h004
`define REG_STATUS      12'h008

// Register layout and reset values
`define SPACING_WIDTH   16
`define SPACING_RESET   16'h00B4
`define ST_TXEN         0
`define ST_EMPTY        1
`define ST_FULL         2
`define ST_READY        3
`define ST_OPER         4

`endif

// ===== dac_sample_feeder.v
// DAC sample feeder: rounding, crossing buffer, DAC handshake, tx enable
`timescale 1ns/100ps
`include "dac_feeder_consts.vh"
// Interface notes
//
// Register port
//    Zero wait states: pready is tied high
//    Read data loaded on the setup edge
//    Unmapped address: error in access phase, write dropped
//    Underrun flag at 0x000, bit 0; any write clears it
//    Spacing at 0x004, low sixteen bits, read and write
//    Status at 0x008: enable, empty, full, offered, operating
//
// Sample stream
//    One I/Q word per control cycle at most
//    I in the upper half, Q in the lower half
//    Ready is simply buffer not full, so no bubble on refill
//    Rounding adds half an output step, then drops four bits
//    Positive overflow clamps to full scale; negative cannot overflow
//
// Crossing buffer
//    Read side stepped by detected DAC clock edges
//    DAC clock sampled by the control clock, two flops deep
//    Control clock must run well above twice the DAC clock
//    Slower control clock misses DAC edges and starves the DAC
//    Pointers carry one extra bit to tell full from empty
//    Depth must stay a power of two for that wrap bit
//
// DAC handshake
//    Ready and data change only on a detected DAC edge
//    A seen take or nothing offered pulls the next sample
//    Take passes the same two flops as the clock, so they align
//    Empty buffer at a take: ready drops and underrun is flagged
//    Last sample stays on the outputs while ready is low
//
// Event input
//    Message taken only while the spacing hold is over
//    Hold restarts at spacing minus one after each message
//    Spacing of zero or one gives no hold at all
//    Messages outside the operating state are spaced but ignored
//    New spacing value applies from the next message on
//
// Transmit enable
//    Neither instance connected: on while either one operates
//    Otherwise the OR of both votes, so both must send off
//    Peer signals share this clock and need no synchroniser
//    Tie peer present low when this instance stands alone
//    Enable registered once, one cycle after the message state
//
// Known limits
//    No initialization-time override of the enable here
//    Underrun set beats a clearing write in the same cycle
//    Register offsets and status layout are local choices

module dac_sample_feeder #(
   parameter FIFO_DEPTH       = `FIFO_DEPTH,
   parameter INPUT_WORD_WIDTH = `IN_WORD_WIDTH
) (
   // Control clock and reset
   input  wire                        clk_i,
   input  wire                        reset_i,
   // APB register port
   input  wire                        psel_i,
   input  wire                        penable_i,
   input  wire                        pwrite_i,
   input  wire [`ADDR_WIDTH-1:0]      paddr_i,
   input  wire [31:0]                 pwdata_i,
   output wire [31:0]                 prdata_o,
   output wire                        pready_o,
   output wire                        pslverr_o,
   // Sample stream input
   input  wire                        in_valid_i,
   input  wire [INPUT_WORD_WIDTH-1:0] in_data_i,
   output wire                        in_ready_o,
   // Transmit event input
   input  wire                        event_connected_i,
   input  wire                        event_valid_i,
   input  wire                        event_on_i,
   output wire                        event_ready_o,
   // Operating state and peer instance
   input  wire                        operating_i,
   input  wire                        peer_present_i,
   input  wire                        peer_operating_i,
   input  wire                        peer_connected_i,
   input  wire                        peer_vote_i,
   output wire                        vote_o,
   // Transmit enable toward transceiver control
   output wire                        txen_o,
   // DAC side
   output wire                        present_o,
   input  wire                        dac_clk_i,
   input  wire                        dac_take_i,
   output wire                        dac_ready_o,
   output wire [`DAC_COMP_WIDTH-1:0]  dac_data_i_o,
   output wire [`DAC_COMP_WIDTH-1:0]  dac_data_q_o
);

   localparam SW = 2 * `DAC_COMP_WIDTH;

   // Message state of the event input
   localparam MSG_NONE = 2'b00;
   localparam MSG_ON   = 2'b01;
   localparam MSG_OFF  = 2'b10;

   // Registers
   reg                      underrun;
   reg [`SPACING_WIDTH-1:0] spacing;
   reg [31:0]               rdata;
   reg                      txen;
   reg [1:0]                msg_state;
   reg [`SPACING_WIDTH-1:0] hold_cnt;

   // Crossing buffer storage and pointers
   reg [SW-1:0]      mem [0:FIFO_DEPTH-1];
   reg [`FIFO_AW:0]  wr_ptr;
   reg [`FIFO_AW:0]  rd_ptr;

   // DAC-side state
   reg               dclk_meta;
   reg               dclk_sync;
   reg               dclk_prev;
   reg               take_meta;
   reg               take_sync;
   reg               ready;
   reg [`DAC_COMP_WIDTH-1:0] data_i;
   reg [`DAC_COMP_WIDTH-1:0] data_q;

   wire              fifo_empty;
   wire              fifo_full;
   wire              push;
   wire              pop;
   wire              dac_edge;
   wire              need_new;
   wire              underrun_evt;
   wire [SW-1:0]     rounded;
   wire              ev_take;
   wire              wr_acc;
   wire              rd_setup;
   wire              addr_ok;
   wire [`SPACING_WIDTH-1:0] next_hold;
   reg               next_txen;

   // Buffer state from pointers; top bit tells wrap
   assign fifo_empty = (wr_ptr == rd_ptr);
   assign fifo_full  = (wr_ptr[`FIFO_AW] != rd_ptr[`FIFO_AW]) &&
                       (wr_ptr[`FIFO_AW-1:0] == rd_ptr[`FIFO_AW-1:0]);

   // Stream stalls while buffer is full
   assign in_ready_o = !fifo_full;
   assign push       = in_valid_i && !fifo_full;

   // Rounding per component, I in the upper lane; same logic twice
   genvar lane;
   generate
      for (lane = 0; lane < 2; lane = lane + 1) begin : g_round
         wire [`IN_COMP_WIDTH-1:0] comp;
         wire [`IN_COMP_WIDTH:0]   sum;
         wire                      ovf;
         // Sign-extend so adding half cannot wrap a negative value
         assign comp = in_data_i[lane*`IN_COMP_WIDTH +: `IN_COMP_WIDTH];
         assign sum  = {comp[`IN_COMP_WIDTH-1], comp} + `ROUND_HALF;
         // Only a positive input can overflow; clamp it to full scale
         assign ovf  = !comp[`IN_COMP_WIDTH-1] && sum[`IN_COMP_WIDTH-1];
         assign rounded[lane*`DAC_COMP_WIDTH +: `DAC_COMP_WIDTH] =
                ovf ? `POS_LIMIT : sum[`IN_COMP_WIDTH-1:`ROUND_SHIFT];
      end
   endgenerate

   // Buffer write side
   always @(posedge clk_i) begin
      if (push)
         mem[wr_ptr[`FIFO_AW-1:0]] <= rounded;
   end

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         wr_ptr <= {(`FIFO_AW+1){1'b0}};
      else if (push)
         wr_ptr <= wr_ptr + 1'b1;
   end

   // DAC clock passes two flops, a third keeps the last level for edges
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         dclk_meta <= 1'b0;
         dclk_sync <= 1'b0;
         dclk_prev <= 1'b0;
      end else begin
         dclk_meta <= dac_clk_i;
         dclk_sync <= dclk_meta;
         dclk_prev <= dclk_sync;
      end
   end

   // Take passes the same two flops, so it lines up with the clock edge
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         take_meta <= 1'b0;
         take_sync <= 1'b0;
      end else begin
         take_meta <= dac_take_i;
         take_sync <= take_meta;
      end
   end

   // One enable per DAC rising edge; rate may change at run time
   assign dac_edge = dclk_sync && !dclk_prev;

   // A new sample is due after take or while nothing is offered
   assign need_new     = dac_edge && (take_sync || !ready);
   assign pop          = need_new && !fifo_empty;
   assign underrun_evt = dac_edge && take_sync && fifo_empty;

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         rd_ptr <= {(`FIFO_AW+1){1'b0}};
      else if (pop)
         rd_ptr <= rd_ptr + 1'b1;
   end

   // Offered sample held until take; ready drops when buffer ran dry
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ready  <= 1'b0;
         data_i <= {`DAC_COMP_WIDTH{1'b0}};
         data_q <= {`DAC_COMP_WIDTH{1'b0}};
      end else if (need_new) begin
         ready <= !fifo_empty;
         if (!fifo_empty) begin
            data_i <= mem[rd_ptr[`FIFO_AW-1:0]][SW-1:`DAC_COMP_WIDTH];
            data_q <= mem[rd_ptr[`FIFO_AW-1:0]][`DAC_COMP_WIDTH-1:0];
         end
      end
   end

   assign dac_ready_o  = ready;
   assign dac_data_i_o = data_i;
   assign dac_data_q_o = data_q;
   assign present_o    = 1'b1;

   // Event input: take a message only when the spacing hold is over
   assign event_ready_o = (hold_cnt == {`SPACING_WIDTH{1'b0}});
   assign ev_take       = event_connected_i && event_valid_i && event_ready_o;

   // Zero spacing must not wrap into a long hold
   assign next_hold = (spacing == {`SPACING_WIDTH{1'b0}}) ?
                      {`SPACING_WIDTH{1'b0}} :
                      spacing - 1'b1;

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         hold_cnt <= {`SPACING_WIDTH{1'b0}};
      else if (ev_take)
         hold_cnt <= next_hold;
      else if (!event_ready_o)
         hold_cnt <= hold_cnt - 1'b1;
   end

   // Last message seen; messages only count while operating
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         msg_state <= MSG_NONE;
      else if (ev_take && operating_i) begin
         case (msg_state)
            MSG_NONE,
            MSG_ON,
            MSG_OFF: msg_state <= event_on_i ? MSG_ON : MSG_OFF;
            default: msg_state <= MSG_NONE;
         endcase
      end
   end

   // Own vote: operating, connected, last message was on
   assign vote_o = operating_i && event_connected_i &&
                   (msg_state == MSG_ON);

   // Combined enable over this instance and an optional peer
   always @* begin
      next_txen = 1'b0;
      if (!event_connected_i &&
          !(peer_present_i && peer_connected_i))
         next_txen = operating_i ||
                     (peer_present_i && peer_operating_i);
      else
         next_txen = vote_o ||
                     (peer_present_i && peer_vote_i);
   end

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         txen <= 1'b0;
      else
         txen <= next_txen;
   end

   assign txen_o = txen;

   // APB decode; zero wait states, read data caught in setup
   assign wr_acc   = psel_i && penable_i && pwrite_i && addr_ok;
   assign rd_setup = psel_i && !penable_i && !pwrite_i;
   assign addr_ok  = (paddr_i == `REG_UNDERRUN) ||
                     (paddr_i == `REG_SPACING) ||
                     (paddr_i == `REG_STATUS);
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !addr_ok;

   // Underrun flag: a new event beats a clearing write
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         underrun <= 1'b0;
      else if (underrun_evt)
         underrun <= 1'b1;
      else if (wr_acc && paddr_i == `REG_UNDERRUN)
         underrun <= 1'b0;
   end

   // Spacing setting, takes effect at the next message
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         spacing <= `SPACING_RESET;
      else if (wr_acc && paddr_i == `REG_SPACING)
         spacing <= pwdata_i[`SPACING_WIDTH-1:0];
   end

   // Read mux registered in the setup phase
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         rdata <= 32'h00000000;
      else if (rd_setup) begin
         rdata <= 32'h00000000;
         case (paddr_i)
            `REG_UNDERRUN: rdata[0] <= underrun;
            `REG_SPACING:  rdata[`SPACING_WIDTH-1:0] <= spacing;
            `REG_STATUS: begin
               rdata[`ST_TXEN]  <= txen;
               rdata[`ST_EMPTY] <= fifo_empty;
               rdata[`ST_FULL]  <= fifo_full;
               rdata[`ST_READY] <= ready;
               rdata[`ST_OPER]  <= operating_i;
            end
            default: rdata <= 32'h00000000;
         endcase
      end
   end

   assign prdata_o = rdata;

endmodule // dac_sample_feeder

// ===== dac_sample_feeder_chk.sv
// Checker of the DAC sample feeder port timing
`timescale 1ns/100ps
module dac_sample_feeder_chk (
   // Control domain
   input wire        clk_i, reset_i, operating_i, peer_operating_i,
   input wire        event_connected_i, peer_connected_i, event_valid_i,
   input wire        event_on_i, event_ready_o, vote_o, txen_o, present_o,
   // DAC side
   input wire        dac_take_i, dac_ready_o,
   input wire [11:0] dac_data_i_o, dac_data_q_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Helper terms; acceptance here is narrower than the design's own
   wire        acc   = event_connected_i && event_valid_i && event_ready_o && operating_i;
   wire        idle  = !operating_i && !peer_operating_i;
   wire        free  = !event_connected_i && !peer_connected_i && operating_i;
   wire        offer = dac_ready_o && !dac_take_i;
   wire [23:0] word  = {dac_data_i_o, dac_data_q_o};
   // Port relations
   a_present_high: assert property (present_o)
      else $error("present indication not high");
   a_event_hold: assert property (acc |=> !event_ready_o [*3])
      else $error("event input not held back after a message");
   a_on_vote: assert property (acc && event_on_i ##1 operating_i |-> vote_o)
      else $error("on message did not raise the vote");
   a_off_vote: assert property (acc && !event_on_i |=> !vote_o)
      else $error("off message left the vote up");
   a_idle_off: assert property (idle [*2] |-> !txen_o)
      else $error("enable high with nothing operating");
   a_free_on: assert property (free [*2] |-> txen_o)
      else $error("enable low with events unconnected");
   a_vote_txen: assert property ($past(vote_o) && $past(event_connected_i) |-> txen_o)
      else $error("enable did not follow the vote");
   a_offer_hold: assert property (offer [*8] |-> $stable(word))
      else $error("offered sample changed before take");
   // Main scenarios reached
   c_event: cover property (acc);
   c_take: cover property (dac_ready_o && dac_take_i);
   c_free: cover property (free && txen_o);
endmodule // dac_sample_feeder_chk
bind dac_sample_feeder dac_sample_feeder_chk chk (.*);

// ===== dac_sink_model.sv
// Behavioural downstream DAC sink: makes the DAC clock and takes samples
`timescale 1ns/100ps
module dac_sink_model (
   // Bench control: clock runs only while set
   input  wire        run_i,
   // Offered sample
   input  wire        ready_i,
   input  wire [11:0] data_i_i, data_q_i,
   // Toward the feeder
   output logic       dac_clk_o, take_o
);
   logic [23:0] got [$];
   // Clock parks low when stopped, so no stray edge reaches the feeder
   initial begin
      dac_clk_o = 1'b0;
      take_o = 1'b0;
      forever begin
         #40;
         if (run_i || dac_clk_o) dac_clk_o = ~dac_clk_o;
      end
   end
   // Latch when offered, then take for exactly one DAC cycle
   always @(posedge dac_clk_o) begin
      if (ready_i) got.push_back({data_i_i, data_q_i});
      take_o <= ready_i;
   end
endmodule // dac_sink_model

// ===== dac_sample_feeder_tb.sv
// Self-checking bench of the DAC sample feeder
`timescale 1ns/100ps
`include "dac_feeder_consts.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WT(c) begin n = 0; while (!(c)) begin @(posedge clk_i); n++; \
   if (n > 3000) begin fails++; final_report; end end end
module dac_sample_feeder_tb;
   // Ports, named as on the feeder
   logic        clk_i, reset_i, psel_i, penable_i, pwrite_i, in_valid_i, run;
   logic        event_connected_i, event_valid_i, event_on_i, operating_i;
   logic        peer_present_i, peer_operating_i, peer_connected_i, peer_vote_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, in_data_i, rd;
   logic        err;
   wire         pready_o, pslverr_o, in_ready_o, event_ready_o, vote_o, txen_o;
   wire         present_o, dac_clk_i, dac_take_i, dac_ready_o;
   wire  [31:0] prdata_o;
   wire  [11:0] dac_data_i_o, dac_data_q_o;
   int          fails = 0, check_count = 0, n, k;
   // Feeder and downstream sink
   dac_sample_feeder dut (.*);
   dac_sink_model sink (.run_i(run), .ready_i(dac_ready_o), .data_i_i(dac_data_i_o),
      .data_q_i(dac_data_q_o), .dac_clk_o(dac_clk_i), .take_o(dac_take_i));
   // Expected rounding: half up, positive overflow saturates
   function logic [23:0] xp(input logic [31:0] w);
      logic [16:0] a, b;
      a = {w[31], w[31:16]} + 17'h00008;
      b = {w[15], w[15:0]} + 17'h00008;
      return {(a[16:15] == 2'b01) ? 12'h7FF : a[15:4], (b[16:15] == 2'b01) ? 12'h7FF : b[15:4]};
   endfunction
   // Test words; the first hits saturation and the most negative value
   function logic [31:0] wd(input int k);
      return (k == 0) ? 32'h7FFF8000 : {k[15:0] * 16'h0A3B, 16'h0008 - k[15:0]};
   endfunction
   task final_report;
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task step(input int c);
      repeat (c) @(posedge clk_i);
      #1;
   endtask
   // APB transfer; read data lands in rd
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      `WT(pready_o)
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // Stream word, valid held across back-to-back calls
   task push(input logic [31:0] d);
      in_valid_i <= 1'b1;
      in_data_i <= d;
      @(posedge clk_i);
      `WT(in_ready_o)
   endtask
   // Message, then the hold that spacing 5 gives
   task ev(input logic on);
      @(posedge clk_i);
      `WT(event_ready_o)
      event_valid_i <= 1'b1;
      event_on_i <= on;
      @(posedge clk_i);
      event_valid_i <= 1'b0;
      repeat (4) begin
         #1 `CHK(event_ready_o, 1'b0)
         @(posedge clk_i);
      end
      #1 `CHK(event_ready_o, 1'b1)
      step(2);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      {reset_i, psel_i, penable_i, pwrite_i, in_valid_i, run} = 6'b100000;
      {event_connected_i, event_valid_i, event_on_i, operating_i} = 4'h0;
      {peer_present_i, peer_operating_i, peer_connected_i, peer_vote_i} = 4'h0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      in_data_i = 32'h0;
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      `CHK(present_o, 1'b1)
      apb(1'b0, `REG_SPACING, 32'h0);
      `CHK(rd, {16'h0000, `SPACING_RESET})
      `CHK(err, 1'b0)
      apb(1'b1, `REG_SPACING, 32'h5);
      apb(1'b0, `REG_SPACING, 32'h0);
      `CHK(rd, 32'h00000005)
      apb(1'b0, 12'hFFC, 32'h0);
      `CHK(rd, 32'h00000000)
      `CHK(err, 1'b1)
      // Single connected instance
      event_connected_i <= 1'b1;
      operating_i <= 1'b1;
      step(3);
      `CHK(txen_o, 1'b0)
      ev(1'b1);
      `CHK(txen_o, 1'b1)
      ev(1'b0);
      `CHK(txen_o, 1'b0)
      // Peer still on keeps enable until it turns off too
      @(posedge clk_i);
      {peer_present_i, peer_operating_i, peer_connected_i, peer_vote_i} <= 4'hF;
      ev(1'b1);
      ev(1'b0);
      `CHK(txen_o, 1'b1)
      @(posedge clk_i);
      peer_vote_i <= 1'b0;
      step(3);
      `CHK(txen_o, 1'b0)
      // Both unconnected, then nothing operating
      @(posedge clk_i);
      {event_connected_i, peer_connected_i, peer_operating_i} <= 3'b000;
      step(3);
      `CHK(txen_o, 1'b1)
      @(posedge clk_i);
      operating_i <= 1'b0;
      step(3);
      `CHK(txen_o, 1'b0)
      // Fill with the DAC stopped; one word more must stall
      @(posedge clk_i);
      for (k = 0; k < 64; k++) push(wd(k));
      in_data_i <= wd(64);
      step(3);
      `CHK(in_ready_o, 1'b0)
      apb(1'b0, `REG_STATUS, 32'h0);
      `CHK(rd, 32'h00000004)
      @(posedge clk_i);
      in_valid_i <= 1'b0;
      run <= 1'b1;
      `WT(sink.got.size() == 64)
      repeat (40) @(posedge clk_i);
      run <= 1'b0;
      `CHK(sink.got.size(), 64)
      for (k = 0; k < 64; k++) `CHK(sink.got[k], xp(wd(k)))
      // Drained past empty: flag set, any write clears
      apb(1'b0, `REG_UNDERRUN, 32'h0);
      `CHK(rd, 32'h00000001)
      apb(1'b1, `REG_UNDERRUN, 32'h1);
      apb(1'b0, `REG_UNDERRUN, 32'h0);
      `CHK(rd, 32'h00000000)
      apb(1'b0, `REG_STATUS, 32'h0);
      `CHK(rd, 32'h00000002)
      final_report;
   end
endmodule // dac_sample_feeder_tb
